//--- logic/asrc_pkg.sv
// Package of constants and types for the serial readout chain
package asrc_pkg;
    localparam int RES_BITS = 14;
    localparam int CHAIN_DLY = 14;
    localparam int FIFO_W = 14;
    localparam int FIFO_D = 8;
    localparam int CLK_MHZ = 200;
    // Longest conversion time in ns and derived cycle count (round down)
    localparam int T_CONV_MAX_NS = 3200;
    localparam int CONV_CYC = (T_CONV_MAX_NS * CLK_MHZ) / 1000;
    localparam logic [RES_BITS-1:0] RES_ZERO = 14'h0000;
    localparam logic [4:0] BIT_LAST = 5'h0D;
    localparam logic [11:0] CNT_ZERO = 12'h000;

    // Interface modes latched at the convert edge
    typedef enum logic {ASRC_MODE_CHAIN = 1'b0, ASRC_MODE_CS = 1'b1} asrc_mode_t;

    // Conversion engine states, Gray along the usual path
    typedef enum logic [1:0] {
        ASRC_IDLE = 2'b00,
        ASRC_CONV = 2'b01,
        ASRC_DONE = 2'b11
    } asrc_state_t;

    // Output pin group
    typedef struct packed {
        logic data;
        logic oe;
        logic busy_en;
    } asrc_sdo_t;
endpackage

//--- logic/asrc_fifo.sv
// Parameterised valid/ready FIFO for conversion results
`timescale 1ns/1ps
module asrc_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;
    logic in_ready_q;
    logic [AW:0] cnt_d;

    // Handshake terms; ready comes from a flip-flop fed by the next count
    assign in_ready = in_ready_q;
    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage write
    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready_q <= 1'b1;
        end
        else
        begin
            if (push)
            begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_d;
            in_ready_q <= (cnt_d != (AW+1)'(DEPTH));
        end
    end
endmodule // asrc_fifo

//--- logic/asrc_core.sv
// Device-side digital readout: convert start, mode select, serial shifter
`timescale 1ns/1ps
module asrc_core (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic convert_strobe,
    input wire logic serial_in,
    input wire logic sck,
    input wire logic [asrc_pkg::RES_BITS-1:0] sample_code,
    input wire logic sample_valid,
    output logic sample_ready,
    output logic serial_out,
    output logic serial_out_oe,
    output logic busy_q,
    output logic mode_cs_q
);
    import asrc_pkg::*;

    logic [2:0] strobe_s_q;
    logic [2:0] serin_s_q;
    logic [2:0] sck_s_q;
    logic strobe_rise;
    logic sck_fall;
    logic strobe_lvl;
    logic serin_lvl;
    logic sel;
    asrc_state_t st_q;
    asrc_mode_t mode_q;
    logic [11:0] conv_cnt_q;
    logic [RES_BITS-1:0] sr_q;
    logic [4:0] bits_q;
    logic shifting_q;
    logic data_q;
    logic oe_q;
    logic busy_en_q;
    logic [RES_BITS-1:0] f_data;
    logic f_valid;
    logic f_ready;

    // Two-flop synchronisers; stage 0 is read only by stage 1
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            strobe_s_q <= '1; // Idle high, so no false convert edge after reset
            serin_s_q <= '1;
            sck_s_q <= '0;
        end
        else
        begin
            strobe_s_q <= {strobe_s_q[1:0], convert_strobe};
            serin_s_q <= {serin_s_q[1:0], serial_in};
            sck_s_q <= {sck_s_q[1:0], sck};
        end
    end

    // Edge and level terms from synchronised stages
    assign strobe_lvl = strobe_s_q[1];
    assign serin_lvl = serin_s_q[1];
    assign strobe_rise = strobe_s_q[1] && !strobe_s_q[2];
    assign sck_fall = !sck_s_q[1] && sck_s_q[2];
    assign sel = !strobe_lvl || !serin_lvl;

    // Result FIFO between sampling front end and shifter
    asrc_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .in_data(sample_code),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .out_data(f_data),
        .out_valid(f_valid),
        .out_ready(f_ready)
    );

    // One FIFO word popped when a conversion completes
    assign f_ready = (st_q == ASRC_CONV) && (conv_cnt_q == CNT_ZERO);

    // Mode latched on the convert edge by serial input level
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            mode_q <= ASRC_MODE_CS;
        end
        else if (strobe_rise)
        begin
            mode_q <= serin_lvl ? ASRC_MODE_CS : ASRC_MODE_CHAIN;
        end
    end

    // Conversion timer on the internal clock, no serial clock needed
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            st_q <= ASRC_IDLE;
            conv_cnt_q <= CNT_ZERO;
        end
        else
        begin
            case (st_q)
                ASRC_IDLE:
                begin
                    if (strobe_rise)
                    begin
                        st_q <= ASRC_CONV;
                        conv_cnt_q <= 12'(CONV_CYC - 1);
                    end
                end
                ASRC_CONV:
                begin
                    if (strobe_rise)
                    begin
                        conv_cnt_q <= 12'(CONV_CYC - 1);
                    end
                    else if (conv_cnt_q != CNT_ZERO)
                    begin
                        conv_cnt_q <= conv_cnt_q - 1'b1;
                    end
                    else
                    begin
                        st_q <= ASRC_DONE;
                    end
                end
                ASRC_DONE:
                begin
                    if (strobe_rise)
                    begin
                        st_q <= ASRC_CONV;
                        conv_cnt_q <= 12'(CONV_CYC - 1);
                    end
                end
                default:
                begin
                    st_q <= ASRC_IDLE;
                end
            endcase
        end
    end

    // Shift register: load result, shift on falling serial clock
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sr_q <= RES_ZERO;
            bits_q <= '0;
            shifting_q <= 1'b0;
        end
        else if (f_ready)
        begin
            sr_q <= f_valid ? f_data : RES_ZERO;
            bits_q <= '0;
            shifting_q <= 1'b1;
        end
        else if (sck_fall && (st_q == ASRC_DONE))
        begin
            if (mode_q == ASRC_MODE_CHAIN)
            begin
                sr_q <= {sr_q[RES_BITS-2:0], serin_lvl};
            end
            else if (sel && shifting_q)
            begin
                sr_q <= {sr_q[RES_BITS-2:0], 1'b0};
                bits_q <= bits_q + 1'b1;
                shifting_q <= (bits_q != BIT_LAST);
            end
        end
    end

    // Busy indication armed if selected at a chip-select mode completion, held through the next conversion
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            busy_en_q <= 1'b0;
        end
        else if (f_ready && (mode_q == ASRC_MODE_CS))
        begin
            busy_en_q <= sel;
        end
    end

    // Output pin drive, all registered
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            data_q <= 1'b0;
            oe_q <= 1'b0;
            busy_q <= 1'b0;
            mode_cs_q <= 1'b1;
        end
        else
        begin
            busy_q <= (st_q == ASRC_CONV);
            mode_cs_q <= (mode_q == ASRC_MODE_CS);
            if (mode_q == ASRC_MODE_CHAIN)
            begin
                oe_q <= 1'b1;
                data_q <= sr_q[RES_BITS-1];
            end
            else
            begin
                oe_q <= sel && (shifting_q || (st_q == ASRC_CONV));
                if (st_q == ASRC_CONV)
                begin
                    data_q <= !busy_en_q; // Armed busy shows low while converting, unarmed shows high
                end
                else
                begin
                    data_q <= sr_q[RES_BITS-1];
                end
            end
        end
    end

    assign serial_out = data_q;
    assign serial_out_oe = oe_q;

    // Assertions
    // Mode and conversion timing checks
    a_conv_start: assert property (@(posedge mclk) disable iff (!rst_n)
        strobe_rise |=> st_q == ASRC_CONV)
        else $error("conversion did not start on convert edge");
    a_busy_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        st_q == ASRC_CONV |=> busy_q)
        else $error("busy flag low during conversion");
    a_mode_chain: assert property (@(posedge mclk) disable iff (!rst_n)
        strobe_rise && !serin_lvl |=> mode_q == ASRC_MODE_CHAIN)
        else $error("chain mode not taken");
    a_mode_cs: assert property (@(posedge mclk) disable iff (!rst_n)
        strobe_rise && serin_lvl |=> mode_q == ASRC_MODE_CS)
        else $error("chip-select mode not taken");
    a_conv_len: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(st_q == ASRC_CONV) |-> ##[1:700] st_q != ASRC_CONV)
        else $error("conversion exceeded longest time");

    // Shifter and output pin checks
    a_oe_desel: assert property (@(posedge mclk) disable iff (!rst_n)
        mode_q == ASRC_MODE_CS && !sel |=> !serial_out_oe)
        else $error("output driven while deselected");
    a_oe_sel: assert property (@(posedge mclk) disable iff (!rst_n)
        mode_q == ASRC_MODE_CS && sel && shifting_q && st_q == ASRC_DONE |=> serial_out_oe)
        else $error("output not enabled while selected");
    a_busy_arm: assert property (@(posedge mclk) disable iff (!rst_n)
        f_ready && mode_q == ASRC_MODE_CS && !strobe_rise |=> busy_en_q == $past(sel))
        else $error("busy indication not armed by select");
    a_busy_low: assert property (@(posedge mclk) disable iff (!rst_n)
        mode_q == ASRC_MODE_CS && st_q == ASRC_CONV && sel && busy_en_q
        |=> serial_out_oe && !serial_out)
        else $error("armed busy level not shown low");
    a_bits_cap: assert property (@(posedge mclk) disable iff (!rst_n)
        bits_q <= BIT_LAST + 5'h01)
        else $error("more than one result shifted out");
    a_chain_oe: assert property (@(posedge mclk) disable iff (!rst_n)
        mode_q == ASRC_MODE_CHAIN |=> serial_out_oe)
        else $error("chain output not driven");
    a_chain_shift: assert property (@(posedge mclk) disable iff (!rst_n)
        sck_fall && st_q == ASRC_DONE && mode_q == ASRC_MODE_CHAIN && !f_ready
        |=> sr_q[0] == $past(serin_lvl))
        else $error("chain input not shifted in");
    a_shift_msb: assert property (@(posedge mclk) disable iff (!rst_n)
        f_ready && f_valid |=> sr_q == $past(f_data))
        else $error("result not loaded msb first");
    a_shift_stop: assert property (@(posedge mclk) disable iff (!rst_n)
        bits_q == BIT_LAST && sck_fall && sel && shifting_q && !f_ready
        && st_q == ASRC_DONE && mode_q == ASRC_MODE_CS |=> !shifting_q)
        else $error("shifter not stopped after last bit");
    a_sr_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        !sck_fall && !f_ready |=> $stable(sr_q))
        else $error("shifter moved without a serial clock fall");
    a_load_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        f_ready && !f_valid |=> sr_q == RES_ZERO)
        else $error("empty buffer did not load zero code");

    // Cover points for the main scenarios
    c_chain: cover property (@(posedge mclk) disable iff (!rst_n)
        strobe_rise && !serin_lvl);
    c_cs: cover property (@(posedge mclk) disable iff (!rst_n)
        strobe_rise && serin_lvl);
    c_done: cover property (@(posedge mclk) disable iff (!rst_n)
        f_ready && f_valid);
    c_full: cover property (@(posedge mclk) disable iff (!rst_n) !sample_ready);
    c_busy: cover property (@(posedge mclk) disable iff (!rst_n)
        busy_en_q && st_q == ASRC_CONV && sel);
endmodule // asrc_core

//--- verification/asrc_host_model.sv
// Host-side serial controller model driving the readout chain
`timescale 1ns/1ps
module asrc_host_model (
    input wire logic mclk,
    output logic convert_strobe,
    output logic serial_in,
    output logic sck,
    input wire logic serial_out,
    output logic [13:0] rx_word,
    output logic rx_stb
);
    import asrc_pkg::*;
    // Idle levels: strobe high, deselected, serial clock parked low
    initial
    begin
        convert_strobe = 1'b1;
        serial_in = 1'b1;
        sck = 1'b0;
        rx_word = 14'h0000;
        rx_stb = 1'b0;
    end
    // Convert pulse, mode level set up well before the rising edge
    task automatic start(input logic cs);
        serial_in <= cs;
        convert_strobe <= 1'b0;
        repeat (4) @(posedge mclk);
        convert_strobe <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask
    // Select level for chip-select reads
    task automatic sel(input logic v);
        serial_in <= v;
        repeat (8) @(posedge mclk);
    endtask
    // Clock out n words at 125 ns; din feeds the chain during the first word
    task automatic read(input int n, input logic [13:0] din);
        for (int w = 0; w < n; w++)
        begin
            for (int b = 13; b >= 0; b--)
            begin
                sck <= 1'b1;
                repeat (6) @(posedge mclk);
                rx_word <= {rx_word[12:0], serial_out};
                serial_in <= (w == 0) ? din[b] : 1'b0;
                repeat (6) @(posedge mclk);
                sck <= 1'b0;
                repeat (13) @(posedge mclk);
            end
            rx_stb <= 1'b1;
            @(posedge mclk);
            rx_stb <= 1'b0;
        end
    endtask
endmodule // asrc_host_model

//--- verification/tb_top.sv
// Self-checking bench for the serial readout chain
`timescale 1ns/1ps
module tb_top;
    import asrc_pkg::*;
    logic mclk;
    logic rst_n;
    logic convert_strobe;
    logic serial_in;
    logic sck;
    logic [RES_BITS-1:0] sample_code;
    logic sample_valid;
    logic sample_ready;
    logic serial_out;
    logic serial_out_oe;
    logic busy_q;
    logic mode_cs_q;
    logic [13:0] rx_word;
    logic rx_stb;
    logic [13:0] code;
    logic [13:0] din;
    logic [13:0] exp_q[$];
    int err_count = 0;
    int checked = 0;
    int seed = 32'h8C60;
    int bcnt;

    asrc_core i_dut (.mclk(mclk), .rst_n(rst_n), .convert_strobe(convert_strobe),
        .serial_in(serial_in), .sck(sck), .sample_code(sample_code),
        .sample_valid(sample_valid), .sample_ready(sample_ready), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .busy_q(busy_q), .mode_cs_q(mode_cs_q));
    asrc_host_model i_host (.mclk(mclk), .convert_strobe(convert_strobe),
        .serial_in(serial_in), .sck(sck), .serial_out(serial_out), .rx_word(rx_word),
        .rx_stb(rx_stb));

    // Clock of 5 ns
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic check(input logic [13:0] seen, input logic [13:0] exp, input string msg);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("Counts: %0d checks, %0d mismatches", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Offer one code; note it as expected only if the buffer takes it
    task automatic push(input logic [13:0] c, input logic rdy);
        @(posedge mclk);
        sample_code <= c;
        sample_valid <= 1'b1;
        @(negedge mclk);
        check({13'h0000, sample_ready}, {13'h0000, rdy}, "buffer ready");
        if (sample_ready === 1'b1)
            exp_q.push_back(c);
        @(posedge mclk);
        sample_valid <= 1'b0;
    endtask

    // Start a conversion and time the busy phase under bounded waits
    // With early set, select during the conversion and check the busy level shown
    task automatic convert(input logic cs, input logic early, input logic exp_low);
        int n;
        n = 0;
        i_host.start(cs);
        if (early)
        begin
            i_host.sel(1'b0);
            check({12'h000, serial_out_oe, serial_out}, {13'h0001, !exp_low}, "busy");
        end
        while (busy_q !== 1'b1 && n < 20)
        begin
            @(posedge mclk);
            n++;
        end
        bcnt = 0;
        while (busy_q === 1'b1 && bcnt < 1000)
        begin
            @(posedge mclk);
            bcnt++;
        end
        if (n >= 20 || bcnt >= 1000)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: conversion wait ran out", $time);
            report_and_stop();
        end
        check({13'h0000, mode_cs_q}, {13'h0000, cs}, "mode latch");
    endtask

    // Chip-select read: select, shift fourteen bits, expect release
    task automatic cs_read();
        i_host.sel(1'b0);
        check({13'h0000, serial_out_oe}, 14'h0001, "output enable");
        i_host.read(1, 14'h0000);
        check({13'h0000, serial_out_oe}, 14'h0000, "output release");
        i_host.sel(1'b1);
    endtask

    // Compare each word the host assembles with the oldest note
    always @(posedge mclk)
    begin
        if (rx_stb === 1'b1)
        begin
            if (exp_q.size() == 0)
            begin
                err_count++;
                $display("CHECK FAILED at %0t: word with nothing expected", $time);
            end
            else
                check(rx_word, exp_q.pop_front(), "serial word");
        end
    end

    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        sample_code = 14'h0000;
        sample_valid = 1'b0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        // Fill past the depth while the host stalls; end codes first
        for (int i = 0; i <= FIFO_D; i++)
        begin
            code = (i == 0) ? 14'h3FFF : (i == 1) ? 14'h0000 : 14'($random(seed));
            push(code, i < FIFO_D);
        end
        $display("Test buffer fill done");
        // Drain by chip-select reads; the last finds the buffer empty
        for (int i = 0; i <= FIFO_D; i++)
        begin
            if (i == FIFO_D)
                exp_q.push_back(RES_ZERO);
            convert(1'b1, 1'b0, 1'b0);
            if (i == 0)
                check(14'(bcnt), 14'(CONV_CYC), "busy length");
            cs_read();
        end
        $display("Test chip-select drain done");
        // Busy level: unarmed first, then armed by select held over completion
        convert(1'b1, 1'b1, 1'b0);
        convert(1'b1, 1'b1, 1'b1);
        i_host.sel(1'b1);
        $display("Test busy indication done");
        // Chain: own word, then the chained input fourteen clocks later
        code = 14'($random(seed));
        din = 14'($random(seed));
        push(code, 1'b1);
        exp_q.push_back(din);
        convert(1'b0, 1'b0, 1'b0);
        i_host.read(2, din);
        repeat (10) @(posedge mclk);
        check(14'(exp_q.size()), 14'h0000, "words left over");
        $display("Test chain mode done");
        report_and_stop();
    end
endmodule // tb_top
